// file: verilog/clock_timer_pkg.sv
// Constants, register map and field layout of the divider clock timer
package clock_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int unsigned CLK_PERIOD_PS       = 5000;
  localparam int unsigned PS_PER_SEC          = 1000000000;
  localparam int unsigned CLK_HZ              = (PS_PER_SEC / CLK_PERIOD_PS) * 1000;
  localparam int unsigned SRC_HZ              = 256;
  localparam int unsigned PRESCALE_CYCLES_DEF = CLK_HZ / SRC_HZ;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int unsigned ADR_W    = 10;
  localparam int unsigned DAT_W    = 32;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned IDX_W    = 8;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned LANE_REG = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TAPS    = 8'he3;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN  = 8'heb;
  localparam logic [IDX_W-1:0] IDX_FLAGS   = 8'hef;
  localparam logic [IDX_W-1:0] IDX_RESTART = 8'hf9;

  ////////////////////////////////////////////////////////////////////////////////
  // Divider layout: counter bit k runs at 128 Hz / 2^k
  localparam int unsigned DIV_WIDTH = 7;
  localparam int unsigned TAP_LSB   = 3;
  localparam int unsigned BIT_32HZ  = 2;
  localparam int unsigned BIT_8HZ   = 4;
  localparam int unsigned BIT_2HZ   = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Event, enable and restart fields
  localparam int unsigned EVENT_W     = 3;
  localparam int unsigned EV_32HZ     = 0;
  localparam int unsigned EV_8HZ      = 1;
  localparam int unsigned EV_2HZ      = 2;
  localparam int unsigned RESTART_BIT = 0;

  localparam logic [EVENT_W-1:0]   EVENT_RST = 3'h0;
  localparam logic [EVENT_W-1:0]   ENABLE_RST = 3'h0;
  localparam logic [DIV_WIDTH-1:0] COUNT_RST = 7'h00;
  localparam logic [DAT_W-1:0]     DATA_ZERO = 32'h0000_0000;

endpackage : clock_timer_pkg

// file: verilog/clock_timer_divider.sv
// Seven-bit binary divider with per-bit falling-edge pulses
`timescale 1ns/1ps
module clock_timer_divider
  import clock_timer_pkg::*;
#(
  parameter int unsigned WIDTH = DIV_WIDTH
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             restart,
  input  wire logic             tick,
  output logic      [WIDTH-1:0] count,
  output logic      [WIDTH-1:0] falling
);

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;

  ////////////////////////////////////////////////////////////////////////////////
  // Counting
  always_comb begin
    nxt_count = count_ff + WIDTH'(1);
  end

  always_ff @(posedge mclk) begin
    if (reset || restart) begin
      count_ff <= '0;
    end else if (tick) begin
      count_ff <= nxt_count;
    end
  end

  // A bit falls when it is 1 now and 0 after the increment;
  // clearing by restart is not a tap edge
  always_comb begin
    falling = {WIDTH{tick & ~restart}} & count_ff & ~nxt_count;
  end

  assign count = count_ff;

endmodule : clock_timer_divider

// file: verilog/divider_clock_timer_irq.sv
// Clock timer: prescaler, divider taps, event flags and Wishbone registers
//
// Behaviour
// R1 - A seven-bit binary divider counts a 256 Hz prescaled clock, giving taps 128 Hz to 2 Hz.
// R2 - The top four taps read as a nibble at index e3 and writes there are ignored.
// R3 - Nibble bits 0..3 carry the 16, 8, 4 and 2 Hz taps, reading 1 while the tap is high.
// R4 - After reset the tap nibble reads zero.
// R5 - Three enable bits at index eb are writable and read back as stored.
// R6 - Enable bits 0, 1, 2 govern the 32, 8 and 2 Hz interrupts and clear on reset.
// R7 - Unused bits of the enable, flag and restart registers read as zero.
// R8 - The 32, 8 and 2 Hz event flags set on the falling edge of their tap.
// R9 - The event flags sit at index ef bits 0..2 for 32, 8 and 2 Hz.
// R10 - A flag sets on its edge whether or not its interrupt is enabled.
// R11 - Reading the flag register returns the flags then clears them; writes do nothing.
// R12 - Reset clears all three event flags.
// R13 - Software reading flags with interrupts enabled must allow for a race with new events.
// R14 - Writing 1 to bit 0 at index f9 clears the divider, which resumes at once; 0 does nothing.
// R15 - The restart bit is write-only and reads as zero.
// R16 - Software changes enable bits only while the processor has interrupts disabled.
// R17 - The interrupt request is high while any flag is set with its enable bit set.
`timescale 1ns/1ps
module divider_clock_timer_irq
  import clock_timer_pkg::*;
#(
  parameter int unsigned PRESCALE_CYCLES = PRESCALE_CYCLES_DEF
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [DAT_W-1:0] dat_i,
  input  wire logic [SEL_W-1:0] sel_i,
  output logic                  ack_o,
  output logic      [DAT_W-1:0] dat_o,
  output logic                  timerIrq
);

  localparam int unsigned PS_W = (PRESCALE_CYCLES > 1) ? $clog2(PRESCALE_CYCLES) : 1;
  localparam logic [PS_W-1:0] PS_LAST = PS_W'(PRESCALE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                 ack_ff;
  logic [DAT_W-1:0]     rdData_ff;
  logic [EVENT_W-1:0]   enable_ff;
  logic [EVENT_W-1:0]   flags_ff;
  logic                 irq_ff;
  logic [PS_W-1:0]      psCount_ff;

  logic [EVENT_W-1:0]   nxt_enable;
  logic [EVENT_W-1:0]   nxt_flags;
  logic [PS_W-1:0]      nxt_psCount;
  logic [DAT_W-1:0]     nxt_rdData;

  logic                 busAccept;
  logic                 rdAccept;
  logic                 wrAccept;
  logic [IDX_W-1:0]     regIndex;
  logic [NIBBLE_W-1:0]  wrNibble;
  logic                 restartReq;
  logic                 srcTick;
  logic [DIV_WIDTH-1:0] divCount;
  logic [DIV_WIDTH-1:0] divFalling;
  logic [EVENT_W-1:0]   eventHits;
  logic [EVENT_W-1:0]   flagClear;
  logic [NIBBLE_W-1:0]  tapNibble;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word index from a byte address
  function automatic logic [IDX_W-1:0] wordIndex(input logic [ADR_W-1:0] adr);
    wordIndex = adr[IDX_LSB +: IDX_W];
  endfunction : wordIndex

  // Register data lives in the low nibble of byte lane 0
  function automatic logic [NIBBLE_W-1:0] lowNibble(input logic [DAT_W-1:0] data);
    lowNibble = data[NIBBLE_W-1:0];
  endfunction : lowNibble

  // Place a register value in the low bits; upper bits read zero
  function automatic logic [DAT_W-1:0] padWord(input logic [NIBBLE_W-1:0] nib);
    padWord = {{(DAT_W - NIBBLE_W){1'b0}}, nib};
  endfunction : padWord

  // Three-bit field widened to a nibble with bit 3 at zero
  function automatic logic [NIBBLE_W-1:0] padField(input logic [EVENT_W-1:0] field);
    padField = {{(NIBBLE_W - EVENT_W){1'b0}}, field};
  endfunction : padField

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Request taken once per transfer: the cycle before ack
  always_comb begin
    busAccept = cyc_i & stb_i & ~ack_ff;
    rdAccept  = busAccept & ~we_i;
    wrAccept  = busAccept & we_i & sel_i[LANE_REG];
    regIndex  = wordIndex(adr_i);
    wrNibble  = lowNibble(dat_i);
  end

  // Write of 0 to the restart bit is a no-op
  always_comb begin
    restartReq = wrAccept && (regIndex == IDX_RESTART) && wrNibble[RESTART_BIT]; // R14
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone acknowledge

  // One wait-free cycle; ack drops in the cycle after it was given
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= busAccept;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler to the 256 Hz source tick

  always_comb begin
    if (restartReq || (psCount_ff == PS_LAST)) begin
      nxt_psCount = '0;
    end else begin
      nxt_psCount = psCount_ff + PS_W'(1);
    end
    srcTick = (psCount_ff == PS_LAST) && !restartReq; // R1
  end

  // Restart also clears the prescaler so the first tap period is full
  always_ff @(posedge mclk) begin
    if (reset) begin
      psCount_ff <= '0;
    end else begin
      psCount_ff <= nxt_psCount; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divider

  clock_timer_divider #(
    .WIDTH   (DIV_WIDTH)
  ) u_divider (
    .mclk    (mclk),
    .reset   (reset),
    .restart (restartReq),
    .tick    (srcTick),
    .count   (divCount),
    .falling (divFalling)
  );

  // Upper four divider bits are the 16..2 Hz taps; zero after reset
  always_comb begin
    tapNibble = divCount[TAP_LSB +: NIBBLE_W]; // R3 R4
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event detection

  always_comb begin
    eventHits          = '0;
    eventHits[EV_32HZ] = divFalling[BIT_32HZ]; // R8
    eventHits[EV_8HZ]  = divFalling[BIT_8HZ];  // R8
    eventHits[EV_2HZ]  = divFalling[BIT_2HZ];  // R8
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flags

  // Cleared by the read that returns them; writes never touch them
  always_comb begin
    if (rdAccept && (regIndex == IDX_FLAGS)) begin
      flagClear = '1; // R11
    end else begin
      flagClear = '0;
    end
  end

  // An edge in the clearing cycle survives the read; the enable is not looked at
  always_comb begin
    nxt_flags = (flags_ff & ~flagClear) | eventHits; // R10 R13
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_ff <= EVENT_RST; // R12
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt enables

  // No guard against changes while interrupts run; that is up to software
  always_comb begin
    if (wrAccept && (regIndex == IDX_IRQ_EN)) begin
      nxt_enable = wrNibble[EVENT_W-1:0]; // R5 R16
    end else begin
      nxt_enable = enable_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_ff <= ENABLE_RST; // R6
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt request

  // Registered, so the request follows the flags by one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(flags_ff & enable_ff); // R17 R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  // Unmapped indices answer with zero rather than an error
  always_comb begin
    case (regIndex)
      IDX_TAPS: begin
        nxt_rdData = padWord(tapNibble); // R2 R3
      end
      IDX_IRQ_EN: begin
        nxt_rdData = padWord(padField(enable_ff)); // R5 R7
      end
      IDX_FLAGS: begin
        nxt_rdData = padWord(padField(flags_ff)); // R9 R7
      end
      IDX_RESTART: begin
        nxt_rdData = DATA_ZERO; // R15 R7
      end
      default: begin
        nxt_rdData = DATA_ZERO;
      end
    endcase
  end

  // Data stands only with ack, zero otherwise
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdData_ff <= DATA_ZERO;
    end else if (rdAccept) begin
      rdData_ff <= nxt_rdData;
    end else begin
      rdData_ff <= DATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Tap register has no write path at all
  assign ack_o    = ack_ff;   // R2
  assign dat_o    = rdData_ff;
  assign timerIrq = irq_ff;

endmodule : divider_clock_timer_irq

// file: test/divider_clock_timer_irq_chk.sv
// Port-level assertions for the divider clock timer
`timescale 1ns/1ps
module divider_clock_timer_irq_chk
  import clock_timer_pkg::*;
#(
  parameter int unsigned PRESCALE_CYCLES = PRESCALE_CYCLES_DEF
) (
  input wire logic             mclk,
  input wire logic             reset,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [DAT_W-1:0] dat_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic             ack_o,
  input wire logic [DAT_W-1:0] dat_o,
  input wire logic             timerIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Word index, so $past sees a plain signal
  logic [IDX_W-1:0] idx;
  assign idx = adr_i[ADR_W-1:IDX_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  a_ack_follows_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_data_idle_zero: assert property (!ack_o |-> dat_o == DATA_ZERO)
    else $error("read data not zero outside ack");
  a_data_upper_zero: assert property (ack_o |-> dat_o[DAT_W-1:4] == 28'h0000000)
    else $error("upper read data bits not zero");
  a_enable_top_zero: assert property (
    ack_o && $past(idx) == IDX_IRQ_EN && !$past(we_i) |-> !dat_o[3])
    else $error("enable register bit 3 not zero");
  a_flag_top_zero: assert property (
    ack_o && $past(idx) == IDX_FLAGS && !$past(we_i) |-> !dat_o[3])
    else $error("flag register bit 3 not zero");
  a_restart_reads_zero: assert property (
    ack_o && $past(idx) == IDX_RESTART && !$past(we_i) |-> dat_o == DATA_ZERO)
    else $error("restart register read not zero");
  a_reset_quiet: assert property ($fell(reset) |-> !timerIrq && !ack_o)
    else $error("outputs active right after reset");

  c_flags_seen: cover property (ack_o && $past(idx) == IDX_FLAGS && dat_o[2]);
  c_irq_rise: cover property ($rose(timerIrq));
  c_restart: cover property (cyc_i && stb_i && we_i && idx == IDX_RESTART && dat_i[0]);
endmodule : divider_clock_timer_irq_chk

bind divider_clock_timer_irq divider_clock_timer_irq_chk #(
  .PRESCALE_CYCLES(PRESCALE_CYCLES)
) chk_i (
  .mclk(mclk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .dat_o(dat_o),
  .timerIrq(timerIrq)
);

// file: test/divider_clock_timer_irq_bench.sv
// Self-checking bench for the divider clock timer
`timescale 1ns/1ps
module divider_clock_timer_irq_bench
  import clock_timer_pkg::*;
;
  typedef struct packed {
    logic w; logic [3:0] s; logic [7:0] idx; logic [3:0] d; logic [3:0] e;
  } row_t;

  // Short prescale keeps a full divider wrap at 1024 cycles
  localparam int unsigned PRE = 8;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] dat = '0;
  logic [SEL_W-1:0] sel = '0;
  logic             ack;
  logic [DAT_W-1:0] rdat;
  logic             irq;
  logic [DAT_W-1:0] q;
  int               errCount = 0;
  int               nChecks = 0;
  int               cycles = 0;
  int               n;
  row_t             rows [14];

  always #2.5 mclk = ~mclk;

  divider_clock_timer_irq #(.PRESCALE_CYCLES(PRE)) divider_clock_timer_irq_i (
    .mclk(mclk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(dat), .sel_i(sel), .ack_o(ack), .dat_o(rdat), .timerIrq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Classic cycle; ack is sampled at the edge, request released after it
  task automatic bus(input logic w, input logic [7:0] i, input logic [3:0] s,
                     input logic [3:0] d, output logic [31:0] r);
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'b00}; sel <= s; dat <= {28'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : bus

  task automatic waitIrq();
    n = 0;
    while (irq !== 1'b1 && n < 1100) begin
      @(posedge mclk);
      n++;
    end
  endtask : waitIrq

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      errCount++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{1'b1, 4'hf, IDX_RESTART, 4'h1, 4'h0}, '{1'b0, 4'hf, IDX_IRQ_EN, 4'h0, 4'h0},
             '{1'b0, 4'hf, IDX_FLAGS, 4'h0, 4'h0}, '{1'b1, 4'hf, IDX_IRQ_EN, 4'hf, 4'h0},
             '{1'b0, 4'hf, IDX_IRQ_EN, 4'h0, 4'h7}, '{1'b1, 4'h0, IDX_IRQ_EN, 4'h0, 4'h0},
             '{1'b0, 4'hf, IDX_IRQ_EN, 4'h0, 4'h7}, '{1'b1, 4'hf, IDX_TAPS, 4'hf, 4'h0},
             '{1'b0, 4'hf, IDX_TAPS, 4'h0, 4'h0}, '{1'b0, 4'hf, IDX_RESTART, 4'h0, 4'h0},
             '{1'b1, 4'hf, IDX_FLAGS, 4'h7, 4'h0}, '{1'b0, 4'hf, IDX_FLAGS, 4'h0, 4'h0},
             '{1'b0, 4'hf, 8'h00, 4'h0, 4'h0}, '{1'b1, 4'hf, IDX_IRQ_EN, 4'h0, 4'h0}};
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    foreach (rows[k]) begin
      bus(rows[k].w, rows[k].idx, rows[k].s, rows[k].d, q);
      if (!rows[k].w) check(q, {28'h0, rows[k].e});
    end
    // Each enable alone: irq fires at its tap's fall, taps and flags match
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, IDX_RESTART, 4'hf, 4'h1, q);
      bus(1'b0, IDX_FLAGS, 4'hf, 4'h0, q);
      bus(1'b1, IDX_IRQ_EN, 4'hf, 4'(1 << k), q);
      waitIrq();
      bus(1'b0, IDX_TAPS, 4'hf, 4'h0, q);
      check(q, (k == 0) ? 32'h1 : (k == 1) ? 32'h4 : 32'h0);
      bus(1'b0, IDX_FLAGS, 4'hf, 4'h0, q);
      check(q, (k == 0) ? 32'h1 : (k == 1) ? 32'h3 : 32'h7);
      repeat (2) @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, IDX_IRQ_EN, 4'hf, 4'h0, q);
    end
    // Reset in mid-run with the interrupt pending
    bus(1'b1, IDX_IRQ_EN, 4'hf, 4'h1, q);
    waitIrq();
    check({31'h0, irq}, 32'h1);
    // Counter sits at 8 here: a write of 0 keeps it, a write of 1 clears it
    bus(1'b1, IDX_RESTART, 4'hf, 4'h0, q);
    bus(1'b0, IDX_TAPS, 4'hf, 4'h0, q);
    check(q, 32'h1);
    bus(1'b1, IDX_RESTART, 4'hf, 4'h1, q);
    bus(1'b0, IDX_TAPS, 4'hf, 4'h0, q);
    check(q, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, IDX_IRQ_EN, 4'hf, 4'h0, q);
    check(q, 32'h0);
    bus(1'b0, IDX_FLAGS, 4'hf, 4'h0, q);
    check(q, 32'h0);
    results();
  end
endmodule : divider_clock_timer_irq_bench
